// ---- hdl/pew_ctrl.sv ----
// Host-side write and polling controller for a parallel EEPROM
`timescale 1ns/100ps

// Operation
// - Host waits full program time unless polling shows completion.
// - After poll completion wait post_poll_write_delay before next write.
// - Each byte load uses write-strobe or chip-select controlled timing.
// - Between page byte loads output enable may pulse; used here for host reads.
// - Polling uses ordinary read cycles with read timing.
module pew_ctrl
#(
	parameter int PROG_CYC = pew_pkg::PROG_TIME_CYC
)
(
	input  wire logic                       core_clk,
	input  wire logic                       srst,
	input  wire pew_pkg::pew_req_t          req,
	input  wire logic                       req_valid,
	output logic                            req_ready,
	output logic                            busy,
	output logic [pew_pkg::DATA_W-1:0]      rd_data,
	output logic                            rd_valid,
	output logic                            chip_sel_n,
	output logic                            out_en_n,
	output logic                            wr_en_n,
	output logic [pew_pkg::ADDR_W-1:0]      addr,
	output logic [pew_pkg::DATA_W-1:0]      data_out,
	output logic                            data_oe,
	input  wire logic [pew_pkg::DATA_W-1:0] data_in
);
	typedef enum logic [2:0] {
		PEW_IDLE, PEW_WSTB, PEW_WREC, PEW_RSTB, PEW_POLL, PEW_PGAP,
		PEW_HOLD
	} pew_state_t;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	pew_state_t                 state_reg, state_next;
	pew_pkg::pew_pins_t         pins_reg, pins_next;
	logic [pew_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
	logic [pew_pkg::CNT_W-1:0]  prog_reg, prog_next;
	logic                       open_reg, open_next;
	logic                       rdy_reg, rdy_next;
	logic [pew_pkg::DATA_W-1:0] rdat_reg, rdat_next;
	logic                       rval_reg, rval_next;
	logic                       dbit_reg, dbit_next;
	logic                       busy_reg, busy_next;

	localparam pew_pkg::pew_pins_t PINS_IDLE = '{
		chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1,
		addr: '0, data_out: '0, data_oe: 1'b0};

	always_comb
	begin
		state_next = state_reg;
		pins_next  = pins_reg;
		cnt_next   = cnt_reg;
		prog_next  = prog_reg;
		open_next  = open_reg;
		rdy_next   = 1'b0;
		rdat_next  = rdat_reg;
		rval_next  = 1'b0;
		dbit_next  = dbit_reg;
		if (cnt_reg != '0)
			cnt_next = cnt_reg - 1'b1;
		if (prog_reg != '0)
			prog_next = prog_reg - 1'b1;
		case (state_reg)
			PEW_IDLE:
			begin
				// Open page: close it and start programming once the window lapses
				if (open_reg && cnt_reg == '0)
				begin
					open_next = 1'b0;
					prog_next = pew_pkg::CNT_W'(PROG_CYC);
					cnt_next  = pew_pkg::CNT_W'(pew_pkg::POLL_GAP_CYC);
					state_next = PEW_PGAP;
				end
				else if (req_valid && !rdy_reg && req.wr)
				begin
					// Write-strobe controlled byte load
					pins_next = '{chip_sel_n: 1'b0, out_en_n: 1'b1,
						wr_en_n: 1'b0, addr: req.addr,
						data_out: req.data, data_oe: 1'b1};
					cnt_next  = pew_pkg::CNT_W'(pew_pkg::STROBE_CYC);
					open_next = !req.last;
					rdy_next  = 1'b1;
					state_next = PEW_WSTB;
				end
				else if (req_valid && !rdy_reg)
				begin
					pins_next = '{chip_sel_n: 1'b0, out_en_n: 1'b0,
						wr_en_n: 1'b1, addr: req.addr,
						data_out: '0, data_oe: 1'b0};
					cnt_next  = pew_pkg::CNT_W'(pew_pkg::ACCESS_CYC);
					rdy_next  = 1'b1;
					state_next = PEW_RSTB;
				end
			end
			PEW_WSTB:
				if (cnt_reg == '0)
				begin
					pins_next.wr_en_n    = 1'b1;
					pins_next.chip_sel_n = 1'b1;
					dbit_next = pins_reg.data_out[pew_pkg::DATA_W-1];
					cnt_next  = pew_pkg::CNT_W'(pew_pkg::STROBE_CYC);
					state_next = PEW_WREC;
				end
			PEW_WREC:
				if (cnt_reg == '0)
				begin
					pins_next = PINS_IDLE;
					// Keep the address: polling must read the last byte
					pins_next.addr = pins_reg.addr;
					if (open_reg)
					begin
						// Window timer; byte loads must arrive in time
						cnt_next = pew_pkg::CNT_W'(pew_pkg::BLC_MAX_CYC);
						state_next = PEW_IDLE;
					end
					else
					begin
						prog_next = pew_pkg::CNT_W'(PROG_CYC);
						cnt_next  = pew_pkg::CNT_W'(pew_pkg::POLL_GAP_CYC);
						state_next = PEW_PGAP;
					end
				end
			PEW_RSTB:
				if (cnt_reg == '0)
				begin
					rdat_next = data_in;
					rval_next = 1'b1;
					pins_next = PINS_IDLE;
					// Restart the page window after the read
					cnt_next  = open_reg ?
						pew_pkg::CNT_W'(pew_pkg::BLC_MAX_CYC) : '0;
					state_next = PEW_IDLE;
				end
			PEW_PGAP:
				if (prog_reg == '0)
				begin
					// Full program time elapsed, no poll needed
					cnt_next = pew_pkg::CNT_W'(pew_pkg::POST_POLL_CYC);
					state_next = PEW_HOLD;
				end
				else if (cnt_reg == '0)
				begin
					// Data polling: a plain read of the last byte's address, or of address 0 when a host read was the last access to an open page
					pins_next.chip_sel_n = 1'b0;
					pins_next.out_en_n   = 1'b0;
					cnt_next  = pew_pkg::CNT_W'(pew_pkg::ACCESS_CYC);
					state_next = PEW_POLL;
				end
			PEW_POLL:
				if (cnt_reg == '0)
				begin
					pins_next.chip_sel_n = 1'b1;
					pins_next.out_en_n   = 1'b1;
					if (data_in[pew_pkg::DATA_W-1] == dbit_reg)
					begin
						cnt_next = pew_pkg::CNT_W'(pew_pkg::POST_POLL_CYC);
						state_next = PEW_HOLD;
					end
					else
					begin
						cnt_next = pew_pkg::CNT_W'(pew_pkg::POLL_GAP_CYC);
						state_next = PEW_PGAP;
					end
				end
			PEW_HOLD:
				if (cnt_reg == '0)
				begin
					prog_next  = '0;
					state_next = PEW_IDLE;
				end
			default:
			begin
				state_next = PEW_IDLE;
				pins_next  = PINS_IDLE;
			end
		endcase
		busy_next = (state_next != PEW_IDLE);
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			state_reg <= PEW_IDLE;
			pins_reg  <= PINS_IDLE;
			cnt_reg   <= '0;
			prog_reg  <= '0;
			open_reg  <= 1'b0;
			rdy_reg   <= 1'b0;
			rdat_reg  <= '0;
			rval_reg  <= 1'b0;
			dbit_reg  <= 1'b0;
			busy_reg  <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			pins_reg  <= pins_next;
			cnt_reg   <= cnt_next;
			prog_reg  <= prog_next;
			open_reg  <= open_next;
			rdy_reg   <= rdy_next;
			rdat_reg  <= rdat_next;
			rval_reg  <= rval_next;
			dbit_reg  <= dbit_next;
			busy_reg  <= busy_next;
		end
	end

	assign req_ready  = rdy_reg;
	assign rd_data    = rdat_reg;
	assign rd_valid   = rval_reg;
	assign chip_sel_n = pins_reg.chip_sel_n;
	assign out_en_n   = pins_reg.out_en_n;
	assign wr_en_n    = pins_reg.wr_en_n;
	assign addr       = pins_reg.addr;
	assign data_out   = pins_reg.data_out;
	assign data_oe    = pins_reg.data_oe;
	assign busy       = busy_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_poll_done;
		state_reg == PEW_POLL && cnt_reg == '0 &&
			data_in[pew_pkg::DATA_W-1] == dbit_reg;
	endsequence

	sequence s_page_lapse;
		state_reg == PEW_IDLE && open_reg && cnt_reg == '0;
	endsequence

	a_no_bus_fight: assert property (@(posedge core_clk) disable iff (srst)
		data_oe |-> out_en_n)
		else $error("Data driven while output enable low");
	a_write_strobe: assert property (@(posedge core_clk) disable iff (srst)
		$fell(wr_en_n) |-> (!chip_sel_n && data_oe) [*2])
		else $error("Write strobe too short");
	a_poll_read: assert property (@(posedge core_clk) disable iff (srst)
		$fell(out_en_n) |-> (wr_en_n && !chip_sel_n) [*4])
		else $error("Poll read not a proper read cycle");
	a_post_poll_wait: assert property (@(posedge core_clk) disable iff (srst)
		s_poll_done |=> wr_en_n [*8])
		else $error("Write too soon after poll");
	a_prog_guard: assert property (@(posedge core_clk) disable iff (srst)
		(prog_reg != '0) |-> wr_en_n)
		else $error("Write during programming");
	a_page_close: assert property (@(posedge core_clk) disable iff (srst)
		s_page_lapse |=> state_reg == PEW_PGAP && prog_reg != '0)
		else $error("Page not closed after load window");
endmodule

// ---- hdl/pew_pkg.sv ----
// Constants and carrier types for the parallel EEPROM write controller
package pew_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 50;
	// Timing in own units, cycle counts derived (min rounds up, max down)
	localparam int PROG_TIME_MS = 5;
	localparam int PROG_TIME_CYC =
		(PROG_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POST_POLL_US = 10;
	localparam int POST_POLL_CYC =
		(POST_POLL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_NS = 50;
	localparam int STROBE_CYC =
		(STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int ACCESS_NS = 150;
	localparam int ACCESS_CYC =
		(ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int BLC_MAX_US = 100;
	localparam int BLC_MAX_CYC = (BLC_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int POLL_GAP_CYC = 4;
	localparam int CNT_W = 20;

	typedef struct packed {
		logic              chip_sel_n;
		logic              out_en_n;
		logic              wr_en_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data_out;
		logic              data_oe;
	} pew_pins_t;

	typedef struct packed {
		logic              wr;
		logic              last;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} pew_req_t;
endpackage

// ---- testbench/pew_dev_model.sv ----
// Behavioural model of the byte-wide EEPROM behind the controller
`timescale 1ns/100ps
module pew_dev_model
#(
	parameter int WIN_CYC  = 40,
	parameter int PROG_CYC = 150
)
(
	input  wire logic                       core_clk,
	input  wire logic                       chip_sel_n,
	input  wire logic                       out_en_n,
	input  wire logic                       wr_en_n,
	input  wire logic [pew_pkg::ADDR_W-1:0] addr,
	input  wire logic [pew_pkg::DATA_W-1:0] data_in,
	output logic [pew_pkg::DATA_W-1:0]      dq,
	output logic                            drv,
	output int                              bad_wr
);
	logic [7:0] mem [0:255];
	logic [7:0] last_reg = 8'h00;
	int         timer_reg = 0;
	int         since_reg = 1000;
	logic       wr_act;
	logic       armed = 1'b0;
	// Write only while selected, strobed and not reading
	assign wr_act = !chip_sel_n && !wr_en_n && out_en_n;
	// Off the bus unless selected for a read
	assign drv = !chip_sel_n && !out_en_n && wr_en_n;
	// Bit 7 inverted until programming is over
	assign dq = (timer_reg > 0) ? {~last_reg[7], last_reg[6:0]}
		: mem[addr[7:0]];
	initial
		bad_wr = 0;
	// Load taken as the earlier strobe rises; both may rise at once
	always @(wr_act)
	begin
		if (wr_act === 1'b1)
			armed = 1'b1;
		else if (armed)
		begin
			armed = 1'b0;
			if ((timer_reg > 0 && timer_reg <= PROG_CYC)
				|| since_reg < pew_pkg::POST_POLL_CYC)
				bad_wr++;
			else
			begin
				mem[addr[7:0]] = data_in;
				last_reg = data_in;
				timer_reg = WIN_CYC + PROG_CYC;
			end
		end
	end
	always @(posedge core_clk)
	begin
		if (timer_reg == 1)
			since_reg = 0;
		else if (timer_reg == 0 && since_reg < 1000)
			since_reg++;
		if (timer_reg > 0)
			timer_reg--;
	end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the EEPROM write controller
`timescale 1ns/100ps
module testbench;
	logic              core_clk = 1'b0;
	logic              srst = 1'b1;
	pew_pkg::pew_req_t req = '0;
	logic              req_valid = 1'b0;
	logic              req_ready;
	logic              busy;
	logic [7:0]        rd_data;
	logic              rd_valid;
	logic              chip_sel_n;
	logic              out_en_n;
	logic              wr_en_n;
	logic [14:0]       addr;
	logic [7:0]        data_out;
	logic              data_oe;
	logic [7:0]        data_in;
	logic [7:0]        dq;
	logic              drv;
	logic [7:0]        last_bus = 8'h00;
	int                bad_wr;
	int                num_errors = 0;
	int                total_checks = 0;
	int                cyc = 0;
	always #25 core_clk = ~core_clk;
	// Released bus shows the inverse of its last level
	assign data_in = drv ? dq : (data_oe ? data_out : ~last_bus);
	pew_ctrl #(.PROG_CYC(200)) u_pew_ctrl (.core_clk(core_clk),
		.srst(srst), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .busy(busy), .rd_data(rd_data),
		.rd_valid(rd_valid), .chip_sel_n(chip_sel_n),
		.out_en_n(out_en_n), .wr_en_n(wr_en_n), .addr(addr),
		.data_out(data_out), .data_oe(data_oe), .data_in(data_in));
	pew_dev_model u_pew_dev_model (.core_clk(core_clk),
		.chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
		.wr_en_n(wr_en_n), .addr(addr), .data_in(data_out),
		.dq(dq), .drv(drv), .bad_wr(bad_wr));
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic xfer(input logic wr, input logic last,
		input logic [14:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge core_clk);
		req = '{wr: wr, last: last, addr: a, data: d};
		req_valid = 1'b1;
		@(negedge core_clk);
		while (req_ready !== 1'b1 && n < 50)
		begin
			@(negedge core_clk);
			n++;
		end
		check("req_ready", {7'h00, req_ready}, 8'h01);
		req_valid = 1'b0;
	endtask
	task automatic rd(input logic [14:0] a, input logic [7:0] exp);
		int n;
		n = 0;
		xfer(1'b0, 1'b0, a, 8'h00);
		while (rd_valid !== 1'b1 && n < 20)
		begin
			@(negedge core_clk);
			n++;
		end
		check("rd_valid", {7'h00, rd_valid}, 8'h01);
		check("rd_data", rd_data, exp);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000)
		begin
			@(negedge core_clk);
			n++;
		end
		check("busy", {7'h00, busy}, 8'h00);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_single;
		xfer(1'b1, 1'b1, 15'h0012, 8'hA5);
		wait_idle();
		rd(15'h0012, 8'hA5);
		$display("test single done");
	endtask
	task automatic t_page;
		xfer(1'b1, 1'b0, 15'h0020, 8'h3C);
		rd(15'h0020, 8'hBC);
		xfer(1'b1, 1'b0, 15'h0021, 8'hC3);
		xfer(1'b1, 1'b1, 15'h0022, 8'h5A);
		wait_idle();
		rd(15'h0020, 8'h3C);
		rd(15'h0021, 8'hC3);
		rd(15'h0022, 8'h5A);
		$display("test page done");
	endtask
	task automatic t_window;
		xfer(1'b1, 1'b0, 15'h0030, 8'h81);
		repeat (2100) @(negedge core_clk);
		wait_idle();
		rd(15'h0030, 8'h81);
		xfer(1'b1, 1'b1, 15'h0031, 8'h7E);
		wait_idle();
		rd(15'h0031, 8'h7E);
		$display("test window done");
	endtask
	always @(negedge core_clk)
		if (!srst && data_oe && drv)
			check("contention", 8'h01, 8'h00);
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			summarize();
		end
	end
	initial
	begin
		repeat (5) @(negedge core_clk);
		srst = 1'b0;
		check("idle_pins", {4'h0, chip_sel_n, out_en_n, wr_en_n, data_oe},
			8'h0E);
		t_single();
		t_page();
		t_window();
		check("bad_wr", bad_wr[7:0], 8'h00);
		summarize();
	end
	always @(posedge core_clk)
		last_bus <= data_in;
endmodule
